//--- logic/ahc_pkg.sv
// Constants and types for the ad-hoc conversion configuration block
package ahc_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STIME_W = 16;

  localparam logic [ADDR_W-1:0] CFG_OFFSET = 16'h110c;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;

  localparam int unsigned CH_LSB = 0;
  localparam int unsigned CH_W = 5;
  localparam int unsigned STIME_BIT = 8;
  localparam int unsigned REF_LSB = 12;
  localparam int unsigned REF_W = 2;

  localparam logic [REF_W-1:0] REF_SUPPLY = 2'h0;
  localparam logic [REF_W-1:0] REF_EXT = 2'h1;
  localparam logic [REF_W-1:0] REF_INT = 2'h2;
  localparam logic [REF_W-1:0] REF_ALIAS_INT = 2'h3;

  localparam logic [CH_W-1:0] CH_RESET = 5'h00;
  localparam logic [REF_W-1:0] REF_RESET = 2'h0;
  localparam logic STIME_SEL_RESET = 1'b0;

  typedef enum logic [1:0] {
    AHC_IDLE = 2'b00,
    AHC_BUSY = 2'b01
  } ahc_fsm_t;

  typedef struct packed {
    logic [CH_W-1:0]    cfg_ch;
    logic               cfg_stime;
    logic [REF_W-1:0]   cfg_ref;
    logic [DATA_W-1:0]  rdata;
    logic               err;
    ahc_fsm_t           fsm;
    logic [CH_W-1:0]    act_ch;
    logic [2:0]         act_ref;
    logic [STIME_W-1:0] act_stime;
  } ahc_state_t;

endpackage : ahc_pkg

//--- logic/ahc_ref_decode.sv
// Reference field to one-hot reference select decoder
`timescale 1ns/10ps
`default_nettype none

module ahc_ref_decode (
  input  wire logic [1:0] ref_field,
  output logic            sel_supply,
  output logic            sel_ext,
  output logic            sel_int
);

  always_comb begin
    sel_supply = 1'b0;
    sel_ext    = 1'b0;
    sel_int    = 1'b0;
    case (ref_field)
      ahc_pkg::REF_SUPPLY:    sel_supply = 1'b1;
      ahc_pkg::REF_EXT:       sel_ext    = 1'b1;
      ahc_pkg::REF_INT:       sel_int    = 1'b1;
      ahc_pkg::REF_ALIAS_INT: sel_int    = 1'b1;
      default:                sel_int    = 1'b1;
    endcase
  end

endmodule : ahc_ref_decode

`default_nettype wire

//--- logic/ahc_adhoc_cfg.sv
// APB register and settings capture for ad-hoc single conversions
// What this block does
// - Ad-hoc conversion uses the register's settings
// - Reference field: supply, external pin, internal
// - Reference value three acts as internal
// - Bit 8 picks first or second compare
// - Bits 4-0 give the input channel number
// - Register at 110Ch, resets to zero
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module ahc_adhoc_cfg (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ahc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ahc_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [ahc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [ahc_pkg::STIME_W-1:0] sample_time_compare_first,
  input  wire logic [ahc_pkg::STIME_W-1:0] sample_time_compare_second,
  input  wire logic                        adhoc_start,
  input  wire logic                        adhoc_done,
  output logic                             conv_busy,
  output logic      [ahc_pkg::CH_W-1:0]    conv_channel,
  output logic                             conv_ref_supply,
  output logic                             conv_ref_ext,
  output logic                             conv_ref_int,
  output logic      [ahc_pkg::STIME_W-1:0] conv_sample_time
);

  ahc_pkg::ahc_state_t st_reg;
  ahc_pkg::ahc_state_t st_next;

  logic                        addr_hit;
  logic                        setup_ph;
  logic                        access_ph;
  logic                        wr_en;
  logic [ahc_pkg::DATA_W-1:0]  cfg_word;
  logic                        dec_supply;
  logic                        dec_ext;
  logic                        dec_int;
  logic [ahc_pkg::STIME_W-1:0] stime_pick;

  // Word decode only; byte offset bits are not checked
  assign addr_hit  = (paddr[ahc_pkg::ADDR_W-1:2] ==
                      ahc_pkg::CFG_OFFSET[ahc_pkg::ADDR_W-1:2]);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite & addr_hit;

  // Reserved bits are never stored, so they always read zero
  always_comb begin
    cfg_word = ahc_pkg::CFG_RESET;
    cfg_word[ahc_pkg::CH_LSB +: ahc_pkg::CH_W] = st_reg.cfg_ch;
    cfg_word[ahc_pkg::STIME_BIT] = st_reg.cfg_stime;
    cfg_word[ahc_pkg::REF_LSB +: ahc_pkg::REF_W] = st_reg.cfg_ref;
  end

  ahc_ref_decode i_ahc_ref_decode (
    .ref_field  (st_reg.cfg_ref),
    .sel_supply (dec_supply),
    .sel_ext    (dec_ext),
    .sel_int    (dec_int)
  );

  assign stime_pick = st_reg.cfg_stime ? sample_time_compare_second
                                       : sample_time_compare_first;

  always_comb begin
    st_next = st_reg;

    // Read data is captured in setup so the access phase needs no wait
    if (setup_ph) begin
      st_next.err   = ~addr_hit;
      st_next.rdata = (addr_hit && !pwrite) ? cfg_word
                                            : ahc_pkg::CFG_RESET;
    end

    if (wr_en) begin
      if (pstrb[0]) begin
        st_next.cfg_ch = pwdata[ahc_pkg::CH_LSB +: ahc_pkg::CH_W];
      end
      if (pstrb[1]) begin
        st_next.cfg_stime = pwdata[ahc_pkg::STIME_BIT];
        st_next.cfg_ref =
          pwdata[ahc_pkg::REF_LSB +: ahc_pkg::REF_W];
      end
    end

    // Settings are frozen at start so mid-conversion writes are harmless
    case (st_reg.fsm)
      ahc_pkg::AHC_IDLE: begin
        if (adhoc_start) begin
          st_next.fsm       = ahc_pkg::AHC_BUSY;
          st_next.act_ch    = st_reg.cfg_ch;
          st_next.act_ref   = {dec_int, dec_ext, dec_supply};
          st_next.act_stime = stime_pick;
        end
      end
      ahc_pkg::AHC_BUSY: begin
        if (adhoc_done) begin
          st_next.fsm = ahc_pkg::AHC_IDLE;
        end
      end
      default: begin
        st_next.fsm = ahc_pkg::AHC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.cfg_ch    <= ahc_pkg::CH_RESET;
      st_reg.cfg_stime <= ahc_pkg::STIME_SEL_RESET;
      st_reg.cfg_ref   <= ahc_pkg::REF_RESET;
      st_reg.rdata     <= ahc_pkg::CFG_RESET;
      st_reg.err       <= 1'b0;
      st_reg.fsm       <= ahc_pkg::AHC_IDLE;
      st_reg.act_ch    <= ahc_pkg::CH_RESET;
      st_reg.act_ref   <= 3'h1;
      st_reg.act_stime <= 16'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.rdata;
  assign pready           = 1'b1;
  assign pslverr          = access_ph & st_reg.err;
  assign conv_busy        = (st_reg.fsm == ahc_pkg::AHC_BUSY);
  assign conv_channel     = st_reg.act_ch;
  assign conv_ref_supply  = st_reg.act_ref[0];
  assign conv_ref_ext     = st_reg.act_ref[1];
  assign conv_ref_int     = st_reg.act_ref[2];
  assign conv_sample_time = st_reg.act_stime;

endmodule : ahc_adhoc_cfg

`default_nettype wire

//--- verif/ahc_adhoc_cfg_properties.sv
// Port assertions for the ad-hoc conversion register block
`timescale 1ns/10ps
`default_nettype none
module ahc_adhoc_cfg_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adhoc_start,
  input wire logic        adhoc_done,
  input wire logic        conv_busy,
  input wire logic [4:0]  conv_channel,
  input wire logic        conv_ref_supply,
  input wire logic        conv_ref_ext,
  input wire logic        conv_ref_int
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_start: assert property (
    adhoc_start && !conv_busy |=> conv_busy)
    else $error("busy not raised");
  a_busy_end: assert property (conv_busy && adhoc_done |=> !conv_busy)
    else $error("busy not dropped");
  a_start_refused: assert property (
    conv_busy && adhoc_start && !adhoc_done
    |=> $stable(conv_channel) && conv_busy)
    else $error("start taken while busy");
  a_ch_held: assert property (!adhoc_start |=> $stable(conv_channel))
    else $error("channel moved");
  a_ref_onehot: assert property (
    $onehot({conv_ref_supply, conv_ref_ext, conv_ref_int}))
    else $error("reference not one-hot");
  a_resv_zero: assert property (
    psel && penable |-> prdata[31:14] == 0
    && prdata[11:9] == 0 && prdata[7:5] == 0)
    else $error("reserved bits set");
  a_err_decode: assert property (
    psel && penable |-> pslverr == (paddr[15:2] != 14'h0443))
    else $error("wrong error response");
  a_ready_up: assert property (psel |-> pready)
    else $error("ready low");
endmodule : ahc_adhoc_cfg_properties
bind ahc_adhoc_cfg ahc_adhoc_cfg_properties i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adhoc_start(adhoc_start), .adhoc_done(adhoc_done), .conv_busy(conv_busy),
  .conv_channel(conv_channel), .conv_ref_supply(conv_ref_supply),
  .conv_ref_ext(conv_ref_ext), .conv_ref_int(conv_ref_int));
`default_nettype wire

//--- verif/ahc_adhoc_cfg_tb.sv
// Self-checking bench for the ad-hoc conversion register block
`timescale 1ns/10ps
`default_nettype none
module ahc_adhoc_cfg_tb;
  typedef struct packed {
    logic [31:0] wd;
    logic [31:0] rd;
    logic [2:0]  rf;
    logic        st;
  } ahc_row_t;
  localparam logic [15:0] CMP_A = 16'h1234;
  localparam logic [15:0] CMP_B = 16'h8765;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        start = 0, done = 0, busy, rs, re, ri, pready, pslverr, err;
  logic [15:0] paddr = 0, stime;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [3:0]  pstrb = 4'hf;
  logic [4:0]  ch;
  int          bad_count = 0, num_checks = 0;
  // Value 3 of the reference field must still decode as internal
  ahc_row_t rows[4] = '{'{32'h00000000, 32'h00000000, 3'b100, 1'b0},
    '{32'h00001015, 32'h00001015, 3'b010, 1'b0},
    '{32'h00002100, 32'h00002100, 3'b001, 1'b1},
    '{32'hffffffff, 32'h0000311f, 3'b001, 1'b1}};
  always #12.5 pclk = ~pclk;
  ahc_adhoc_cfg i_ahc_adhoc_cfg (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_time_compare_first(CMP_A), .sample_time_compare_second(CMP_B),
    .adhoc_start(start), .adhoc_done(done), .conv_busy(busy),
    .conv_channel(ch), .conv_ref_supply(rs), .conv_ref_ext(re),
    .conv_ref_int(ri), .conv_sample_time(stime));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Start held two edges so the second one hits a busy engine
  task automatic conv(input ahc_row_t r);
    @(posedge pclk);
    start <= 1'b1;
    repeat (2) @(posedge pclk);
    start <= 1'b0;
    done <= 1'b1;
    #1 chk({busy, ch, rs, re, ri}, {1'b1, r.rd[4:0], r.rf});
    chk(stime, r.st ? CMP_B : CMP_A);
    @(posedge pclk);
    done <= 1'b0;
    #1 chk(busy, 1'b0);
  endtask : conv
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({ch, rs, re, ri, stime}, {5'h00, 3'b100, 16'h0000});
    apb(1'b0, 16'h110c, 32'h0);
    chk(rdv, 32'h00000000);
    chk(err, 1'b0);
    foreach (rows[i]) begin
      apb(1'b1, 16'h110c, rows[i].wd);
      apb(1'b0, 16'h110c, 32'h0);
      chk(rdv, rows[i].rd);
      conv(rows[i]);
    end
    apb(1'b1, 16'h1108, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 16'h1108, 32'h0);
    chk(rdv, 32'h00000000);
    chk(err, 1'b1);
    pstrb <= 4'he;
    apb(1'b1, 16'h110c, 32'h0);
    apb(1'b0, 16'h110c, 32'h0);
    chk(rdv, 32'h0000001f);
    // Reset in mid-run must drop captured settings and the register
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({busy, ch, rs, re, ri}, {1'b0, 5'h00, 3'b100});
    chk(stime, 16'h0000);
    apb(1'b0, 16'h110c, 32'h0);
    chk(rdv, 32'h00000000);
    tally_and_finish();
  end
endmodule : ahc_adhoc_cfg_tb
`default_nettype wire
